// >>> sle_regs.svh
// Register offsets, field masks, reset values and timing counts
`ifndef SLE_REGS_SVH
`define SLE_REGS_SVH
`define SLE_ADDR_CTRL 8'h00
`define SLE_ADDR_ERR 8'h04
`define SLE_ADDR_PASV 8'h08
`define SLE_ADDR_STAT 8'h0C
`define SLE_ADDR_MASK 8'h10
`define SLE_ADDR_INFO 8'h14
`define SLE_CTRL_WMASK 32'h00001FFF
`define SLE_ERR_WMASK 32'h00001F1F
`define SLE_CTRL_RST 32'h00000000
`define SLE_ERR_RST 32'h00000000
`define SLE_PASV_RST 32'h00000000
`define SLE_STAT_RST 3'h0
`define SLE_MASK_RST 3'h0
`define SLE_ST_START 0
`define SLE_ST_DONE 1
`define SLE_ST_LINK 2
`define SLE_CLK_KHZ 40000
`define SLE_TICK_MS 25
`define SLE_FLK_T 8'h01
`define SLE_FAST_T 8'h02
`define SLE_SLOW_T 8'h08
`define SLE_SFL_ON 8'h08
`define SLE_SFL_PER 8'h30
`define SLE_PAUSE_T 8'h28
`define SLE_GAP_T 8'h50
`define SLE_BURST_N 6'h08
`endif

// >>> sle_pkg.sv
// Types for the fieldbus status LED encoder
package sle_pkg;
  typedef enum logic [2:0] {
    sle_init_state, sle_mailbox_only_state, sle_inputs_only_state,
    sle_full_run_state, sle_firmware_update_state
  } sle_node_type;
  typedef enum logic [1:0] {sle_no_peer, sle_linked, sle_active}
    sle_port_type;
  typedef enum logic [1:0] {sle_mode_off, sle_mode_run, sle_mode_stop,
    sle_mode_config} sle_mode_type;
  typedef enum logic [2:0] {sle_idle, sle_burst, sle_code, sle_pause,
    sle_reason, sle_gap} sle_seq_type;
  typedef struct packed {
    logic [18:0] rsvd;
    logic boot_usr_val;
    logic boot_usr_en;
    logic spare_val;
    logic spare_en;
    logic boot_fault;
    logic boot_done;
    sle_mode_type mode;
    sle_port_type port;
    sle_node_type node;
  } sle_ctrl_type;
  typedef struct packed {
    logic [18:0] rsvd_hi;
    logic [4:0] pos;
    logic [2:0] rsvd_lo;
    logic [4:0] code;
  } sle_err_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } sle_apb_req_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sle_apb_rsp_type;
endpackage

// >>> sle_top.sv
// Fieldbus node status LED encoder with APB registers
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "sle_regs.svh"
module sle_top import sle_pkg::*; #(
  parameter int unsigned TICK_CYC = `SLE_TICK_MS * `SLE_CLK_KHZ
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // APB slave
  input wire sle_apb_req_type i_apb,
  output sle_apb_rsp_type o_apb,
  // LED drives
  output logic o_state_led,
  output logic o_link_led,
  output logic o_mode_red,
  output logic o_mode_green,
  output logic o_mode_blue,
  output logic o_spare_led,
  output logic o_boot_led,
  output logic o_kbus_run_led,
  output logic o_kbus_err_led,
  // Interrupt
  output logic o_irq
);
  sle_ctrl_type ctrl_r;
  sle_err_type err_r;
  logic [31:0] pasv_r;
  logic [2:0] stat_r;
  logic [2:0] mask_r;
  sle_port_type port_q_r;
  logic [23:0] tcyc_r;
  logic tick_r;
  logic [7:0] bcnt_r;
  logic flk_r;
  sle_seq_type seq_r;
  logic [7:0] tcnt_r;
  logic [5:0] pcnt_r;
  logic lit_r;
  logic [5:0] code_n_r;
  logic [5:0] reason_n_r;
  logic ev_start_r, ev_done_r;
  logic [31:0] act;
  logic [5:0] reason_nxt;
  logic [7:0] hp;
  logic [5:0] tgt;
  logic setup, wr_en;
  logic [2:0] ev;

  assign setup = i_apb.psel && !i_apb.penable;
  assign wr_en = i_apb.psel && i_apb.penable && o_apb.pready &&
    i_apb.pwrite;

  // APB response, one wait-free access phase
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_apb <= '0;
    end else begin
      o_apb.pready <= setup;
      if (setup) begin
        o_apb.pslverr <= 1'b0;
        unique case (i_apb.paddr)
          `SLE_ADDR_CTRL: o_apb.prdata <= ctrl_r;
          `SLE_ADDR_ERR: o_apb.prdata <= err_r;
          `SLE_ADDR_PASV: o_apb.prdata <= pasv_r;
          `SLE_ADDR_STAT: o_apb.prdata <= {29'h0, stat_r};
          `SLE_ADDR_MASK: o_apb.prdata <= {29'h0, mask_r};
          `SLE_ADDR_INFO: o_apb.prdata <= {19'h0, seq_r,
            pcnt_r[3:0], reason_n_r};
          default: begin
            o_apb.prdata <= 32'h0;
            o_apb.pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // Software writable registers
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_r <= sle_ctrl_type'(`SLE_CTRL_RST);
      err_r <= sle_err_type'(`SLE_ERR_RST);
      pasv_r <= `SLE_PASV_RST;
      mask_r <= `SLE_MASK_RST;
    end else if (wr_en) begin
      if (i_apb.paddr == `SLE_ADDR_CTRL)
        ctrl_r <= sle_ctrl_type'(i_apb.pwdata & `SLE_CTRL_WMASK);
      if (i_apb.paddr == `SLE_ADDR_ERR)
        err_r <= sle_err_type'(i_apb.pwdata & `SLE_ERR_WMASK);
      if (i_apb.paddr == `SLE_ADDR_PASV)
        pasv_r <= i_apb.pwdata;
      if (i_apb.paddr == `SLE_ADDR_MASK)
        mask_r <= i_apb.pwdata[2:0];
    end
  end

  // Sticky status; a new event beats a same-cycle clear
  assign ev = {port_q_r != ctrl_r.port, ev_done_r, ev_start_r};
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stat_r <= `SLE_STAT_RST;
      port_q_r <= sle_no_peer;
      o_irq <= 1'b0;
    end else begin
      port_q_r <= ctrl_r.port;
      if (wr_en && i_apb.paddr == `SLE_ADDR_STAT)
        stat_r <= (stat_r & ~i_apb.pwdata[2:0]) | ev;
      else
        stat_r <= stat_r | ev;
      o_irq <= |(stat_r & mask_r);
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tcyc_r <= 24'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tcyc_r == 24'(TICK_CYC - 1));
      tcyc_r <= (tcyc_r == 24'(TICK_CYC - 1)) ? 24'h0 : tcyc_r + 24'h1;
    end
  end
  // Free blink phase counters
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bcnt_r <= 8'h0;
      flk_r <= 1'b0;
    end else if (tick_r) begin
      bcnt_r <= (bcnt_r == `SLE_SFL_PER - 8'h1) ? 8'h0 : bcnt_r + 8'h1;
      if (tcnt_r[0] || `SLE_FLK_T == 8'h01)
        flk_r <= !flk_r;
    end
  end
  generate
    for (genvar i = 0; i < 32; i++) begin : g_act
      assign act[i] = (i >= 1) && (5'(i) <= err_r.pos) && !pasv_r[i];
    end
  endgenerate
  always_comb begin
    reason_nxt = 6'h0;
    for (int j = 0; j < 32; j++)
      reason_nxt = reason_nxt + {5'h0, act[j]};
  end
  // Pulse target only matters in the three pulse phases
  assign tgt = (seq_r == sle_burst) ? `SLE_BURST_N :
    (seq_r == sle_code) ? code_n_r : reason_n_r;
  always_comb begin
    hp = 8'h1;
    unique case (seq_r)
      sle_burst: hp = `SLE_FAST_T;
      sle_code, sle_reason: hp = `SLE_SLOW_T;
      sle_pause: hp = `SLE_PAUSE_T;
      sle_gap: hp = `SLE_GAP_T;
      sle_idle: hp = 8'h1;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      seq_r <= sle_idle;
      tcnt_r <= 8'h0;
      pcnt_r <= 6'h0;
      lit_r <= 1'b0;
      code_n_r <= 6'h0;
      reason_n_r <= 6'h0;
      ev_start_r <= 1'b0;
      ev_done_r <= 1'b0;
    end else begin
      ev_start_r <= 1'b0;
      ev_done_r <= 1'b0;
      if (err_r.code == 5'h0) begin
        seq_r <= sle_idle;
        lit_r <= 1'b0;
        tcnt_r <= 8'h0;
        pcnt_r <= 6'h0;
      end else if (tick_r) begin
        if (seq_r == sle_idle) begin
          seq_r <= sle_burst;
          lit_r <= 1'b1;
          tcnt_r <= 8'h0;
          pcnt_r <= 6'h0;
          code_n_r <= {1'b0, err_r.code};
          reason_n_r <= reason_nxt;
          ev_start_r <= 1'b1;
        end else if (tcnt_r != hp - 8'h1) begin
          tcnt_r <= tcnt_r + 8'h1;
        end else begin
          tcnt_r <= 8'h0;
          unique case (seq_r)
            sle_burst, sle_code, sle_reason: begin
              if (lit_r) begin
                lit_r <= 1'b0;
              end else if (pcnt_r != tgt - 6'h1) begin
                pcnt_r <= pcnt_r + 6'h1;
                lit_r <= 1'b1;
              end else begin
                pcnt_r <= 6'h0;
                if (seq_r == sle_burst) begin
                  seq_r <= sle_code;
                  lit_r <= 1'b1;
                end else if (seq_r == sle_code) begin
                  seq_r <= sle_pause;
                end else begin
                  seq_r <= sle_gap;
                end
              end
            end
            sle_pause: begin
              if (reason_n_r != 6'h0) begin
                seq_r <= sle_reason;
                lit_r <= 1'b1;
              end else begin
                seq_r <= sle_gap;
              end
            end
            sle_gap: begin
              seq_r <= sle_idle;
              ev_done_r <= 1'b1;
            end
            sle_idle: seq_r <= sle_idle;
          endcase
        end
      end
    end
  end

  // LED output flops
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_state_led <= 1'b0;
      o_link_led <= 1'b0;
      {o_mode_red, o_mode_green, o_mode_blue} <= 3'h0;
      o_spare_led <= 1'b0;
      o_boot_led <= 1'b1;
      o_kbus_run_led <= 1'b0;
      o_kbus_err_led <= 1'b0;
    end else begin
      unique case (ctrl_r.node)
        sle_init_state: o_state_led <= 1'b0;
        sle_mailbox_only_state: o_state_led <= bcnt_r[3];
        sle_inputs_only_state: o_state_led <= bcnt_r < `SLE_SFL_ON;
        sle_full_run_state: o_state_led <= 1'b1;
        sle_firmware_update_state: o_state_led <= flk_r;
        default: o_state_led <= 1'b0;
      endcase
      unique case (ctrl_r.port)
        sle_linked: o_link_led <= 1'b1;
        sle_active: o_link_led <= bcnt_r[1];
        default: o_link_led <= 1'b0;
      endcase
      o_mode_green <= ctrl_r.mode == sle_mode_run;
      o_mode_red <= ctrl_r.mode == sle_mode_stop;
      o_mode_blue <= ctrl_r.mode == sle_mode_config;
      o_spare_led <= ctrl_r.spare_en && ctrl_r.spare_val;
      if (ctrl_r.boot_usr_en)
        o_boot_led <= ctrl_r.boot_usr_val;
      else
        o_boot_led <= !ctrl_r.boot_done || ctrl_r.boot_fault;
      o_kbus_run_led <= err_r.code == 5'h0;
      o_kbus_err_led <= lit_r;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  a_init_dark: assert property (
    (ctrl_r.node == sle_init_state)[*2] |-> !o_state_led)
    else $error("state LED lit during init");
  a_full_steady: assert property (
    (ctrl_r.node == sle_full_run_state)[*2] |-> o_state_led)
    else $error("state LED not steady in full run");
  a_fw_flicker: assert property (
    (ctrl_r.node == sle_firmware_update_state)[*2] |->
      o_state_led == $past(flk_r))
    else $error("state LED not following flicker");
  a_link_off: assert property (
    (ctrl_r.port == sle_no_peer)[*2] |-> !o_link_led)
    else $error("link LED lit without peer");
  a_mode_run: assert property (
    ctrl_r.mode == sle_mode_run |=>
      o_mode_green && !o_mode_red && !o_mode_blue)
    else $error("run mode colour wrong");
  a_spare_off: assert property (
    !ctrl_r.spare_en |=> !o_spare_led)
    else $error("spare LED lit while unassigned");
  a_boot_lit: assert property (
    !ctrl_r.boot_usr_en && !ctrl_r.boot_done |=> o_boot_led)
    else $error("boot LED dark before startup done");
  a_run_err: assert property (
    err_r.code != 5'h0 |=> !o_kbus_run_led)
    else $error("run LED lit with error");
  a_err_dark: assert property (
    (err_r.code == 5'h0)[*3] |-> !o_kbus_err_led)
    else $error("error LED lit without error");
  a_seq_order: assert property (
    $past(seq_r) == sle_burst && seq_r != sle_burst |->
      seq_r == sle_code || seq_r == sle_idle)
    else $error("burst not followed by code");
  a_pause_dark: assert property (
    seq_r == sle_pause |-> !lit_r)
    else $error("LED lit during pause");
  a_reason_cnt: assert property (
    $rose(ev_start_r) |-> 32'(reason_n_r) + $countones(pasv_r &
      ((32'h2 << err_r.pos) - 32'h2)) == 32'(err_r.pos))
    else $error("reason count misses passive terminals");
endmodule // sle_top

// >>> fieldbus_status_led_encoder_tb.sv
// Self-checking bench for the status LED encoder
`timescale 1ns/1ps
`include "sle_regs.svh"
module fieldbus_status_led_encoder_tb import sle_pkg::*;;
  // Short tick keeps every blink period within a few hundred cycles
  localparam int SIM_TICK = 4;
  logic i_sys_clk = 1'b0;
  logic i_arst_n = 1'b0;
  sle_apb_req_type apb = '0;
  sle_apb_rsp_type rsp;
  logic st, lk, mr, mg, mb, sp, bt, kr, ke, irq;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int checks_done = 0;
  int son[6] = '{0, 96, 32, 192, 96, 0};
  int sed[6] = '{0, 6, 2, 0, 48, 0};
  int lon[3] = '{0, 192, 96};
  int led[3] = '{0, 0, 24};
  logic [2:0] mexp[4] = '{3'h0, 3'h2, 3'h4, 3'h1};
  sle_top #(.TICK_CYC(SIM_TICK)) uut (.i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n), .i_apb(apb), .o_apb(rsp), .o_state_led(st),
    .o_link_led(lk), .o_mode_red(mr), .o_mode_green(mg),
    .o_mode_blue(mb), .o_spare_led(sp), .o_boot_led(bt),
    .o_kbus_run_led(kr), .o_kbus_err_led(ke), .o_irq(irq));
  initial begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge i_sys_clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    chk(rsp.pready, 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? st : lk;
  endfunction
  // One full blink period: lit samples and level changes
  task automatic meas(input int s, output int on, output int ed);
    logic p;
    on = 0;
    ed = 0;
    @(negedge i_sys_clk);
    p = pick(s);
    repeat (192) begin
      @(negedge i_sys_clk);
      on += int'(pick(s) === 1'b1);
      ed += int'(pick(s) !== p);
      p = pick(s);
    end
  endtask
  task automatic span(input logic v, output int w);
    w = 0;
    while (ke === v && w < 1000) begin
      @(negedge i_sys_clk);
      w++;
    end
  endtask
  function automatic int n_exp(input logic [4:0] p, input logic [31:0] v);
    n_exp = 0;
    for (int i = 1; i <= int'(p); i++) n_exp += int'(!v[i]);
  endfunction
  function automatic logic boot_exp(input logic [3:0] b);
    return b[2] ? b[3] : (!b[0] | b[1]);
  endfunction
  // Pulses split by width (fast 8, slow 32) and long dark spans
  task automatic errseq(input logic [4:0] c, input logic [4:0] p,
      input logic [31:0] v);
    int w, d, g, f;
    int k[2];
    g = 0;
    f = 0;
    k = '{0, 0};
    wr(`SLE_ADDR_PASV, v);
    wr(`SLE_ADDR_ERR, {19'h0, p, 3'h0, c});
    cyc(3);
    chk(kr, 1'b0);
    span(1'b0, w);
    while (g < 2 && f < 40) begin
      span(1'b1, w);
      span(1'b0, d);
      if (w <= 16) begin
        if (g > 0) break;
        f++;
      end else begin
        k[g]++;
        if (d > 64) g++;
      end
    end
    chk(f, 8);
    chk(k[0], c);
    chk(k[1], n_exp(p, v));
    wr(`SLE_ADDR_ERR, 32'h0);
    cyc(3);
    chk(ke, 1'b0);
    chk(kr, 1'b1);
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    summarize();
  end
  initial begin
    int on, ed;
    logic [5:0] b;
    void'($urandom(32'h7a96b76e));
    repeat (12) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    cyc(2);
    chk(bt, 1'b1);
    chk(kr, 1'b1);
    chk(sp, 1'b0);
    xfer(1'b0, `SLE_ADDR_CTRL, 32'h0);
    chk(rd, `SLE_CTRL_RST);
    xfer(1'b0, `SLE_ADDR_ERR, 32'h0);
    chk(rd, `SLE_ERR_RST);
    xfer(1'b0, 8'h18, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    xfer(1'b1, `SLE_ADDR_INFO, 32'h1FFF);
    chk(err, 1'b0);
    for (int i = 0; i < 6; i++) begin
      wr(`SLE_ADDR_CTRL, 32'h80 | i);
      cyc(8);
      meas(0, on, ed);
      chk(on, son[i]);
      chk(ed, sed[i]);
    end
    for (int i = 0; i < 3; i++) begin
      wr(`SLE_ADDR_CTRL, 32'h83 | (i << 3));
      cyc(8);
      meas(1, on, ed);
      chk(on, lon[i]);
      chk(ed, led[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(`SLE_ADDR_CTRL, 32'h83 | (i << 5));
      cyc(4);
      chk({mr, mg, mb}, mexp[i]);
    end
    chk(bt, 1'b0);
    repeat (10) begin
      b = 6'($urandom);
      wr(`SLE_ADDR_CTRL, {19'h0, b[3:2], b[5:4], b[1:0], 7'h03});
      cyc(4);
      chk(bt, boot_exp(b[3:0]));
      chk(sp, b[4] & b[5]);
    end
    wr(`SLE_ADDR_STAT, 32'h7);
    wr(`SLE_ADDR_MASK, 32'h0);
    errseq(5'h3, 5'h4, 32'h4);
    errseq(5'h1, 5'h0, 32'h0);
    repeat (3) begin
      errseq(5'($urandom_range(1, 4)), 5'($urandom_range(1, 12)),
        $urandom & 32'h1FFE);
    end
    xfer(1'b0, `SLE_ADDR_STAT, 32'h0);
    chk(rd[2:0], 3'h3);
    chk(irq, 1'b0);
    wr(`SLE_ADDR_MASK, 32'h1);
    cyc(3);
    chk(irq, 1'b1);
    wr(`SLE_ADDR_STAT, 32'h7);
    cyc(3);
    chk(irq, 1'b0);
    wr(`SLE_ADDR_CTRL, 32'h8B);
    cyc(3);
    chk(irq, 1'b0);
    wr(`SLE_ADDR_MASK, 32'h4);
    cyc(3);
    chk(irq, 1'b1);
    // Reset in mid-sequence must bring the error, boot and run LEDs and the interrupt back to power-up level
    wr(`SLE_ADDR_ERR, 32'h00000105);
    cyc(20);
    chk(kr, 1'b0);
    @(posedge i_sys_clk);
    i_arst_n <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    cyc(2);
    chk(ke, 1'b0);
    chk(bt, 1'b1);
    chk(kr, 1'b1);
    chk(irq, 1'b0);
    xfer(1'b0, `SLE_ADDR_ERR, 32'h0);
    chk(rd, `SLE_ERR_RST);
    summarize();
  end
endmodule // fieldbus_status_led_encoder_tb
